/* File: logic/irq_prio_pkg.sv */
/*
  package for the interrupt priority and source block: register
  offsets, reset values, field positions, carrier structs and states.
  assumes a single 125 MHz core clock and a byte-addressed Avalon-MM slave.
*/
`default_nettype none
package irq_prio_pkg;

  // ==========================================================
  // register offsets (byte addresses, one 32-bit word each)
  // ==========================================================
  localparam logic [7:0] OFS_PERIPHERAL_PRIORITY_1 = 8'h00;
  localparam logic [7:0] OFS_PERIPHERAL_PRIORITY_2 = 8'h04;
  localparam logic [7:0] OFS_PERIPHERAL_PRIORITY_3 = 8'h08;
  localparam logic [7:0] OFS_RESET_CONTROL         = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CONTROL_1         = 8'h10;
  localparam logic [7:0] OFS_IRQ_CONTROL_2         = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL_3         = 8'h18;
  localparam logic [7:0] OFS_PERIPH_FLAG_1         = 8'h1C;
  localparam logic [7:0] OFS_PERIPH_FLAG_2         = 8'h20;
  localparam logic [7:0] OFS_PERIPH_FLAG_3         = 8'h24;
  localparam logic [7:0] OFS_PERIPH_ENABLE_1       = 8'h28;
  localparam logic [7:0] OFS_PERIPH_ENABLE_2       = 8'h2C;
  localparam logic [7:0] OFS_PERIPH_ENABLE_3       = 8'h30;
  localparam logic [7:0] OFS_CAN_MODE              = 8'h34;

  // ==========================================================
  // reset values and implemented-bit masks
  // ==========================================================
  localparam logic [7:0] RST_PRIORITY_1  = 8'hFF;
  localparam logic [7:0] RST_PRIORITY_2  = 8'h5F;
  localparam logic [7:0] RST_PRIORITY_3  = 8'hFF;
  localparam logic [7:0] MASK_PRIORITY_2 = 8'h5F;
  localparam logic [7:0] RST_RESET_CTRL  = 8'h1C;
  localparam logic [7:0] MASK_RESET_CTRL = 8'h9F;
  localparam logic [7:0] RST_IRQ_CTRL_1  = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL_2  = 8'hFF;
  localparam logic [7:0] RST_IRQ_CTRL_3  = 8'hC0;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int BIT_PRIORITY_LEVELS_ENABLE = 7;  // reset_control
  localparam int BIT_GLOBAL_IRQ_ENABLE      = 7;  // irq_control_1
  localparam int BIT_PERIPHERAL_IRQ_ENABLE  = 6;
  localparam int BIT_TIMER_ZERO_IRQ_ENABLE  = 5;
  localparam int BIT_EXT0_IRQ_ENABLE        = 4;
  localparam int BIT_PORT_B_CHANGE_ENABLE   = 3;
  localparam int BIT_EXT0_IRQ_FLAG          = 1;
  localparam int BIT_PORT_B_CHANGE_FLAG     = 0;
  localparam int BIT_TIMER_ZERO_FLAG        = 2;  // irq_control_1 bit 2
  localparam int BIT_EXT3_PRIORITY          = 1;  // irq_control_2
  localparam int BIT_TIMER_ZERO_PRIORITY    = 2;
  localparam int BIT_PORT_B_CHANGE_PRIORITY = 0;
  localparam int BIT_EXT0_EDGE_SELECT       = 6;  // irq_control_2 bits 6..3
  localparam int BIT_EXT1_PRIORITY          = 6;  // irq_control_3
  localparam int BIT_EXT2_PRIORITY          = 7;
  localparam int BIT_EXT1_ENABLE            = 3;  // irq_control_3 bits 5..3
  localparam int BIT_EXT1_FLAG              = 0;  // irq_control_3 bits 2..0
  localparam int BIT_BUF1_PRIORITY          = 3;  // peripheral_priority_3
  localparam int BIT_BUF0_PRIORITY          = 2;
  localparam int BIT_WATERMARK_PRIORITY     = 0;
  localparam int BIT_PARALLEL_SLAVE         = 7;  // peripheral_priority_1

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [1:0] {CAN_MODE_0, CAN_MODE_1, CAN_MODE_2, CAN_MODE_RSVD} can_mode_t;
  typedef enum {BUS_IDLE, BUS_ANSWER} bus_state_t;

  typedef struct packed {
    logic [15:0] return_pc;
    logic [7:0]  working_register;
    logic [7:0]  status_register;
    logic [7:0]  bank_select_register;
  } context_t;

endpackage : irq_prio_pkg
`default_nettype wire

/* File: logic/irq_prio.sv */
/*
  interrupt priority and source logic: priority registers, external
  edge pins, timer-zero and port-b change sources, two-level request
  generation and context capture on entry.
  assumes: Avalon-MM master per its specification; pins asynchronous;
  timer, peripheral flags and core strobes synchronous to MCLK.
*/
// Local design decisions: the register offsets and the Avalon-MM register port.
// Contract
// [RULE1] priority bits act only while priority levels are enabled
// [RULE2] implemented priority bits are read/write, reset to one; one means high
// [RULE3] first priority register: slave port down to timer-one overflow
// [RULE4] second register: bits 6,4,3,2,1,0 implemented; bits 7,5 read zero
// [RULE5] third register holds the CAN source priorities, bits 7 to 1
// [RULE6] third register bit 0 depends on CAN mode: rx0, zero, watermark
// [RULE7] buffer one and zero priority bits forced zero in CAN modes 1, 2
// [RULE8] priority levels enable is reset control bit 7, resets to zero
// [RULE9] reset control bits 6,5 read zero; cause flags reset to 1,1,1,0,0
// [RULE10] external pins edge-triggered, rising when edge select set
// [RULE11] valid edge sets pin flag; cleared enable stops the request
// [RULE12] software clears an external flag before enabling it again
// [RULE13] enabled external flag wakes the processor from sleep
// [RULE14] after wake, vector only if global enable set, else resume
// [RULE15] external interrupt zero is always high priority
// [RULE16] ext1, ext2, ext3 priorities from control-3 bits 6,7 and control-2 bit 1
// [RULE17] timer-zero flag on 8-bit or 16-bit rollover per mode
// [RULE18] timer-zero enable control-1 bit 5, priority control-2 bit 2
// [RULE19] port-b upper change sets control-1 bit 0; enable bit 3, priority bit 0
// [RULE20] interrupt entry pushes return pc on the hardware stack
// [RULE21] entry copies working, status and bank select to the shadow
// [RULE22] without fast return, software saves those registers itself
// [RULE23] in single-level mode peripherals also need the peripheral enable
// [RULE24] with levels on, enabled source goes high if priority one, else low
`default_nettype none
module irq_prio
  import irq_prio_pkg::*;
#(
  parameter int EXT_PINS = 4
)(
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                RESET,
  // avalon-mm register slave
  input  wire logic [7:0]          ADDRESS,
  input  wire logic                READ,
  input  wire logic                WRITE,
  input  wire logic [3:0]          BYTEENABLE,
  input  wire logic [31:0]         WRITEDATA,
  output logic [31:0]              READDATA,
  output logic                     WAITREQUEST,
  // pins
  input  wire logic [EXT_PINS-1:0] EXT_IRQ_PIN,
  input  wire logic [3:0]          PORT_B_UPPER_PIN,
  input  wire logic                PORT_B_READ,
  // sources on the core clock
  input  wire logic                TIMER_ZERO_16BIT,
  input  wire logic [15:0]         TIMER_ZERO_COUNT,
  input  wire logic [23:0]         PERIPH_EVENT,
  input  wire logic                MICROCONTROLLER_MODE,
  // core side
  input  wire logic                SLEEPING,
  input  wire logic                IRQ_ACK,
  input  wire context_t            CORE_CONTEXT,
  output logic                     HIGH_PRIORITY_REQ,
  output logic                     LOW_PRIORITY_REQ,
  output logic                     WAKE,
  output logic                     WAKE_TO_VECTOR,
  output logic                     STACK_PUSH,
  output logic [15:0]              STACK_PUSH_PC,
  output context_t                 SHADOW
);

  // ==========================================================
  // register storage
  // ==========================================================
  logic [7:0] prio [3];
  logic [7:0] reset_control;
  logic [7:0] irq_control_1, irq_control_2, irq_control_3;
  logic [7:0] pflag [3];
  logic [7:0] penable [3];
  can_mode_t  can_mode;
  bus_state_t bus_state;
  logic       wr_strobe;
  logic [7:0] wdata;

  logic [EXT_PINS-1:0] ext_s1, ext_s2, ext_s3, ext_level;
  logic [3:0]  pb_s1, pb_s2, pb_s3, pb_level, pb_latch;
  logic [15:0] tmr_prev;
  logic        ext_edge [EXT_PINS];
  logic        pb_change, tmr_roll;

  // write taken on the answer cycle only
  assign wr_strobe = (bus_state == BUS_ANSWER) && WRITE && BYTEENABLE[0];
  assign wdata     = WRITEDATA[7:0];

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_strobe && (ADDRESS == ofs);
  endfunction : hit

  // ==========================================================
  // bus handshake: one wait cycle then answer
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      bus_state <= BUS_IDLE;
    else if (bus_state == BUS_IDLE && (READ || WRITE))
      bus_state <= BUS_ANSWER;
    else
      bus_state <= BUS_IDLE;
  end

  // waitrequest low only in the answer cycle
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      WAITREQUEST <= 1'b1;
    else
      WAITREQUEST <= !(bus_state == BUS_IDLE && (READ || WRITE));
  end

  // ==========================================================
  // priority registers
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      prio[0] <= RST_PRIORITY_1;                          // [RULE2]
      prio[1] <= RST_PRIORITY_2;
      prio[2] <= RST_PRIORITY_3;
    end
    else
    begin
      if (hit(OFS_PERIPHERAL_PRIORITY_1))
        prio[0] <= wdata;                                 // [RULE3]
      if (hit(OFS_PERIPHERAL_PRIORITY_2))
        prio[1] <= wdata & MASK_PRIORITY_2;               // [RULE4]
      if (hit(OFS_PERIPHERAL_PRIORITY_3))
        prio[2] <= wdata;                                 // [RULE5]
    end
  end

  // third priority register as seen, mode dependent
  function automatic logic [7:0] prio3_view(input logic [7:0] raw, input can_mode_t m);
    logic [7:0] v;
    v = raw;
    if (m != CAN_MODE_0)
    begin
      v[BIT_BUF1_PRIORITY] = 1'b0;                        // [RULE7]
      v[BIT_BUF0_PRIORITY] = 1'b0;
    end
    if (m == CAN_MODE_1)
      v[BIT_WATERMARK_PRIORITY] = 1'b0;                   // [RULE6]
    prio3_view = v;
  endfunction : prio3_view

  // ==========================================================
  // reset control, can mode, peripheral flags and enables
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      reset_control <= RST_RESET_CTRL;                    // [RULE8] [RULE9]
    else if (hit(OFS_RESET_CONTROL))
      reset_control <= {wdata[7], 2'b00, reset_control[4], reset_control[3:2], wdata[1:0]};
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      can_mode <= CAN_MODE_0;
    else if (hit(OFS_CAN_MODE))
      can_mode <= can_mode_t'(wdata[1:0]);
  end

  generate
    for (genvar r = 0; r < 3; r++)
    begin : g_periph
      // hardware set wins over software write
      always_ff @(posedge MCLK)
      begin
        if (RESET)
          pflag[r] <= RST_ZERO;
        else if (hit(OFS_PERIPH_FLAG_1 + 8'(4 * r)))
          pflag[r] <= wdata | PERIPH_EVENT[8*r +: 8];
        else
          pflag[r] <= pflag[r] | PERIPH_EVENT[8*r +: 8];
      end

      always_ff @(posedge MCLK)
      begin
        if (RESET)
          penable[r] <= RST_ZERO;
        else if (hit(OFS_PERIPH_ENABLE_1 + 8'(4 * r)))
          penable[r] <= wdata;
      end
    end
  endgenerate

  // ==========================================================
  // pin synchronisers and edge detection
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ext_s1 <= '0;
      ext_s2 <= '0;
      ext_s3 <= '0;
      ext_level <= '0;
      pb_s1 <= '0;
      pb_s2 <= '0;
      pb_s3 <= '0;
      pb_level <= '0;
    end
    else
    begin
      ext_s1 <= EXT_IRQ_PIN;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      pb_s1 <= PORT_B_UPPER_PIN;
      pb_s2 <= pb_s1;
      pb_s3 <= pb_s2;
      for (int i = 0; i < EXT_PINS; i++)
        if (ext_s2[i] == ext_s3[i])
          ext_level[i] <= ext_s3[i];
      for (int i = 0; i < 4; i++)
        if (pb_s2[i] == pb_s3[i])
          pb_level[i] <= pb_s3[i];
    end
  end

  generate
    for (genvar i = 0; i < EXT_PINS; i++)
    begin : g_edge
      logic agreed;
      assign agreed = (ext_s2[i] == ext_s3[i]);
      // rising when edge select set, falling otherwise
      assign ext_edge[i] = agreed && (ext_s3[i] != ext_level[i]) &&
                           (ext_s3[i] == irq_control_2[BIT_EXT0_EDGE_SELECT - i]); // [RULE10]
    end
  endgenerate

  // port-b mismatch latch refreshed by a port read
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      pb_latch <= '0;
    else if (PORT_B_READ)
      pb_latch <= pb_level;
  end
  assign pb_change = (pb_level != pb_latch);

  // timer-zero rollover
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      tmr_prev <= '0;
    else
      tmr_prev <= TIMER_ZERO_COUNT;
  end
  assign tmr_roll = TIMER_ZERO_16BIT ?
                    (tmr_prev == 16'hFFFF && TIMER_ZERO_COUNT == 16'h0000) :
                    (tmr_prev[7:0] == 8'hFF && TIMER_ZERO_COUNT[7:0] == 8'h00); // [RULE17]

  // ==========================================================
  // control registers; hardware-set flags in control 1 and 3 (set wins)
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      irq_control_1 <= RST_IRQ_CTRL_1;
    else
    begin
      irq_control_1 <= hit(OFS_IRQ_CONTROL_1) ? wdata : irq_control_1;
      if (ext_edge[0])
        irq_control_1[BIT_EXT0_IRQ_FLAG] <= 1'b1;        // [RULE11]
      if (tmr_roll)
        irq_control_1[BIT_TIMER_ZERO_FLAG] <= 1'b1;      // [RULE17]
      if (pb_change)
        irq_control_1[BIT_PORT_B_CHANGE_FLAG] <= 1'b1;   // [RULE19]
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      irq_control_2 <= RST_IRQ_CTRL_2;
    else if (hit(OFS_IRQ_CONTROL_2))
      irq_control_2 <= wdata;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      irq_control_3 <= RST_IRQ_CTRL_3;
    else
    begin
      irq_control_3 <= hit(OFS_IRQ_CONTROL_3) ? wdata : irq_control_3;
      for (int i = 1; i < EXT_PINS; i++)
        if (ext_edge[i])
          irq_control_3[BIT_EXT1_FLAG + i - 1] <= 1'b1;  // [RULE11]
    end
  end

  // ==========================================================
  // request generation
  // ==========================================================
  logic       levels_on, global_irq_enable, peripheral_irq_enable;
  logic [7:0] prio3_eff, prio1_eff;
  logic [3:0] ext_act, ext_pri;
  logic       core_hi, core_lo, periph_hi, periph_lo, periph_any, any_pending;
  logic       next_high, next_low;

  assign levels_on = reset_control[BIT_PRIORITY_LEVELS_ENABLE];
  assign global_irq_enable       = irq_control_1[BIT_GLOBAL_IRQ_ENABLE];
  assign peripheral_irq_enable      = irq_control_1[BIT_PERIPHERAL_IRQ_ENABLE];
  assign prio3_eff = prio3_view(prio[2], can_mode);
  assign prio1_eff = MICROCONTROLLER_MODE ? prio[0] : {1'b0, prio[0][6:0]}; // [RULE3]

  // flag and enable pairs of the external pins
  assign ext_act[0] = irq_control_1[BIT_EXT0_IRQ_FLAG] && irq_control_1[BIT_EXT0_IRQ_ENABLE];
  generate
    for (genvar i = 1; i < 4; i++)
    begin : g_ext_act
      assign ext_act[i] = irq_control_3[BIT_EXT1_FLAG + i - 1] &&
                          irq_control_3[BIT_EXT1_ENABLE + i - 1]; // [RULE11]
    end
  endgenerate

  assign ext_pri = {irq_control_2[BIT_EXT3_PRIORITY], irq_control_3[BIT_EXT2_PRIORITY],
                    irq_control_3[BIT_EXT1_PRIORITY], 1'b1}; // [RULE15] [RULE16]

  always_comb
  begin
    logic tz, pb;
    tz = irq_control_1[BIT_TIMER_ZERO_FLAG] && irq_control_1[BIT_TIMER_ZERO_IRQ_ENABLE];
    pb = irq_control_1[BIT_PORT_B_CHANGE_FLAG] && irq_control_1[BIT_PORT_B_CHANGE_ENABLE];
    core_hi = |(ext_act & ext_pri) ||
              (tz && irq_control_2[BIT_TIMER_ZERO_PRIORITY]) ||  // [RULE18]
              (pb && irq_control_2[BIT_PORT_B_CHANGE_PRIORITY]); // [RULE19]
    core_lo = |(ext_act & ~ext_pri) ||
              (tz && !irq_control_2[BIT_TIMER_ZERO_PRIORITY]) ||
              (pb && !irq_control_2[BIT_PORT_B_CHANGE_PRIORITY]);
    periph_hi = |(pflag[0] & penable[0] & prio1_eff) ||
                |(pflag[1] & penable[1] & prio[1]) ||
                |(pflag[2] & penable[2] & prio3_eff);
    periph_lo = |(pflag[0] & penable[0] & ~prio1_eff) ||
                |(pflag[1] & penable[1] & ~prio[1]) ||
                |(pflag[2] & penable[2] & ~prio3_eff);
    periph_any = periph_hi || periph_lo;
    any_pending = |ext_act || tz || pb || periph_any;
    if (levels_on)
    begin
      next_high = global_irq_enable && (core_hi || periph_hi);             // [RULE24]
      next_low  = global_irq_enable && peripheral_irq_enable && !next_high && (core_lo || periph_lo); // [RULE1]
    end
    else
    begin
      // single-level mode: priorities ignored, all go one way
      next_high = global_irq_enable && (core_hi || core_lo || (peripheral_irq_enable && periph_any)); // [RULE23]
      next_low  = 1'b0;                                      // [RULE1]
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      HIGH_PRIORITY_REQ <= 1'b0;
      LOW_PRIORITY_REQ  <= 1'b0;
    end
    else
    begin
      HIGH_PRIORITY_REQ <= next_high;
      LOW_PRIORITY_REQ  <= next_low;
    end
  end

  // wake from sleep on any enabled pending flag
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      WAKE           <= 1'b0;
      WAKE_TO_VECTOR <= 1'b0;
    end
    else
    begin
      WAKE           <= SLEEPING && any_pending;             // [RULE13]
      WAKE_TO_VECTOR <= SLEEPING && any_pending && global_irq_enable;      // [RULE14]
    end
  end

  // ==========================================================
  // context capture on entry
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      STACK_PUSH    <= 1'b0;
      STACK_PUSH_PC <= '0;
      SHADOW        <= '0;
    end
    else
    begin
      STACK_PUSH <= IRQ_ACK;                                 // [RULE20]
      if (IRQ_ACK)
      begin
        STACK_PUSH_PC <= CORE_CONTEXT.return_pc;
        SHADOW        <= CORE_CONTEXT;                       // [RULE21]
      end
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      READDATA <= UNMAPPED_READ;
    else if (bus_state == BUS_IDLE && READ)
    begin
      if (ADDRESS == OFS_PERIPHERAL_PRIORITY_1)
        READDATA <= {24'h000000, prio[0]};
      else if (ADDRESS == OFS_PERIPHERAL_PRIORITY_2)
        READDATA <= {24'h000000, prio[1]};
      else if (ADDRESS == OFS_PERIPHERAL_PRIORITY_3)
        READDATA <= {24'h000000, prio3_eff};
      else if (ADDRESS == OFS_RESET_CONTROL)
        READDATA <= {24'h000000, reset_control & MASK_RESET_CTRL};
      else if (ADDRESS == OFS_IRQ_CONTROL_1)
        READDATA <= {24'h000000, irq_control_1};
      else if (ADDRESS == OFS_IRQ_CONTROL_2)
        READDATA <= {24'h000000, irq_control_2};
      else if (ADDRESS == OFS_IRQ_CONTROL_3)
        READDATA <= {24'h000000, irq_control_3};
      else if (ADDRESS == OFS_PERIPH_FLAG_1)
        READDATA <= {24'h000000, pflag[0]};
      else if (ADDRESS == OFS_PERIPH_FLAG_2)
        READDATA <= {24'h000000, pflag[1]};
      else if (ADDRESS == OFS_PERIPH_FLAG_3)
        READDATA <= {24'h000000, pflag[2]};
      else if (ADDRESS == OFS_PERIPH_ENABLE_1)
        READDATA <= {24'h000000, penable[0]};
      else if (ADDRESS == OFS_PERIPH_ENABLE_2)
        READDATA <= {24'h000000, penable[1]};
      else if (ADDRESS == OFS_PERIPH_ENABLE_3)
        READDATA <= {24'h000000, penable[2]};
      else if (ADDRESS == OFS_CAN_MODE)
        READDATA <= {30'h0, can_mode};
      else
        READDATA <= UNMAPPED_READ;
    end
  end

endmodule : irq_prio
`default_nettype wire

/* File: dv/irq_prio_monitor.sv */
/* checker on the block ports: bus answer timing, entry capture, wake.
   assumes it is bound onto irq_prio, one clock domain. */
`default_nettype none
module irq_prio_monitor
  import irq_prio_pkg::*;
(
  // watched ports
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  input wire logic        SLEEPING,
  input wire logic        IRQ_ACK,
  input wire context_t    CORE_CONTEXT,
  input wire logic        STACK_PUSH,
  input wire logic [15:0] STACK_PUSH_PC,
  input wire context_t    SHADOW,
  input wire logic        WAKE,
  input wire logic        WAKE_TO_VECTOR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ==========
  // bus answer: one low cycle, then high again
  sequence s_ans;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence
  property p_answer;
    $rose(READ || WRITE) |=> s_ans;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_idle;
    !(READ || WRITE) |=> WAITREQUEST;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rdata;
    READ && !WAITREQUEST |-> READDATA[31:8] == 24'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("upper read bits not zero");
  // ==========
  // entry capture and wake
  property p_push;
    IRQ_ACK |=> STACK_PUSH && STACK_PUSH_PC == $past(CORE_CONTEXT.return_pc);
  endproperty
  a_push: assert property (p_push) else $error("return pc not pushed");
  property p_lone;
    STACK_PUSH |-> $past(IRQ_ACK);
  endproperty
  a_lone: assert property (p_lone) else $error("push without entry");
  property p_shadow;
    IRQ_ACK |=> SHADOW == $past(CORE_CONTEXT);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not captured");
  property p_vec;
    WAKE_TO_VECTOR |-> WAKE;
  endproperty
  a_vec: assert property (p_vec) else $error("vector without wake");
  property p_wake;
    WAKE |-> $past(SLEEPING);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
endmodule : irq_prio_monitor
bind irq_prio irq_prio_monitor mon_i (.MCLK, .RESET, .READ, .WRITE, .READDATA,
  .WAITREQUEST, .SLEEPING, .IRQ_ACK, .CORE_CONTEXT, .STACK_PUSH, .STACK_PUSH_PC,
  .SHADOW, .WAKE, .WAKE_TO_VECTOR);
`default_nettype wire

/* File: dv/irq_core_model.sv */
/* core partner: acks each new request, context changes every cycle.
   assumes requests stay up until software clears the flag. */
`default_nettype none
module irq_core_model
  import irq_prio_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // requests from the block
  input  wire logic hi,
  input  wire logic lo,
  // entry towards the block
  output logic      ack,
  output context_t  ctx,
  output context_t  taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  // one entry per new request, context the block must copy
  always_ff @(posedge clk)
  begin
    ctx <= context_t'({$urandom, 8'($urandom)});
    ack <= !rst && (hi || lo) && !seen;
    seen <= !rst && (hi || lo);
    if (ack)
      taken <= ctx;
  end
endmodule : irq_core_model
`default_nettype wire

/* File: dv/irq_prio_tb.sv */
/* self-checking bench for irq_prio: registers, pins, timer, sleep.
   assumes the core partner model and the bound checker. */
`default_nettype none
module irq_prio_tb
  import irq_prio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, rd = 0, wr = 0, sleep = 0;
  logic [7:0] adr = 0;
  logic [3:0] ben = 4'hF, be = 4'hF, pin = 0;
  logic [31:0] wd = 0, rdata;
  logic [15:0] tcnt = 0, ppc;
  logic wreq, hi, lo, wake, wvec, push, ack;
  context_t ctx, taken, shadow;
  int fails = 0, n_compared = 0;
  logic [7:0] ofs[8] = '{OFS_PERIPHERAL_PRIORITY_1, OFS_PERIPHERAL_PRIORITY_2,
    OFS_PERIPHERAL_PRIORITY_3, OFS_RESET_CONTROL, OFS_IRQ_CONTROL_1,
    OFS_IRQ_CONTROL_2, OFS_IRQ_CONTROL_3, 8'h3C};
  logic [7:0] rst_v[8] = '{8'hFF, 8'h5F, 8'hFF, 8'h1C, 8'h00, 8'hFF, 8'hC0, 8'h00};
  // ==========
  // design, partner and clock
  irq_prio irq_prio_i (.MCLK(clk), .RESET(rst), .ADDRESS(adr), .READ(rd), .WRITE(wr),
    .BYTEENABLE(be), .WRITEDATA(wd), .READDATA(rdata), .WAITREQUEST(wreq),
    .EXT_IRQ_PIN(pin), .PORT_B_UPPER_PIN(4'h0), .PORT_B_READ(1'b0),
    .TIMER_ZERO_16BIT(1'b0), .TIMER_ZERO_COUNT(tcnt), .PERIPH_EVENT(24'h0),
    .MICROCONTROLLER_MODE(1'b1), .SLEEPING(sleep), .IRQ_ACK(ack), .CORE_CONTEXT(ctx),
    .HIGH_PRIORITY_REQ(hi), .LOW_PRIORITY_REQ(lo), .WAKE(wake), .WAKE_TO_VECTOR(wvec),
    .STACK_PUSH(push), .STACK_PUSH_PC(ppc), .SHADOW(shadow));
  irq_core_model irq_core_model_i (.clk(clk), .rst(rst), .hi(hi), .lo(lo), .ack(ack),
    .ctx(ctx), .taken(taken));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // ==========
  // helpers
  function automatic logic [7:0] p3(input int m, input logic [7:0] d);
    return d & (m == 0 ? 8'hFF : 8'hF3) & (m == 1 ? 8'hFE : 8'hFF);
  endfunction : p3
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    rd <= !w; wr <= w; adr <= a; wd <= {24'h0, d}; be <= ben;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    q = rdata;
    rd <= 0; wr <= 0;
    @(posedge clk);
  endtask : bus
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic await_req();
    for (int n = 0; n < 12 && (hi | lo) !== 1'b1; n++)
      @(posedge clk);
  endtask : await_req
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========
  // main sequence
  initial
  begin
    logic [31:0] q;
    logic [7:0] d;
    void'($urandom(32'h0505FA81));
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    foreach (ofs[i])
    begin
      bus(0, ofs[i], 0, q);
      chk("reset value", {24'h0, rst_v[i]}, q);
    end
    ben = 4'h0;
    bus(1, OFS_PERIPHERAL_PRIORITY_1, 8'h00, q);
    ben = 4'hF;
    bus(0, OFS_PERIPHERAL_PRIORITY_1, 0, q);
    chk("lane off", 32'hFF, q);
    for (int i = 0; i < 2; i++)
    begin
      d = 8'($urandom);
      bus(1, ofs[i], d, q);
      bus(0, ofs[i], 0, q);
      chk("prio", {24'h0, i == 1 ? d & 8'h5F : d}, q);
    end
    for (int m = 0; m < 3; m++)
    begin
      d = 8'($urandom);
      bus(1, OFS_CAN_MODE, 8'(m), q);
      bus(1, OFS_PERIPHERAL_PRIORITY_3, d, q);
      bus(0, OFS_PERIPHERAL_PRIORITY_3, 0, q);
      chk("prio3", {24'h0, p3(m, d)}, q);
    end
    bus(1, OFS_RESET_CONTROL, 8'hFF, q);
    bus(0, OFS_RESET_CONTROL, 0, q);
    chk("reset control", 32'h9F, q);
    bus(1, OFS_IRQ_CONTROL_1, 8'h90, q);
    pin <= 4'h1;
    await_req();
    chk("ext0 high", 2'b10, {hi, lo});
    repeat (4) @(posedge clk);
    chk("pushed pc", taken.return_pc, ppc);
    chk("shadow", taken, shadow);
    bus(0, OFS_IRQ_CONTROL_1, 0, q);
    chk("ext0 flag", 32'h92, q);
    bus(1, OFS_IRQ_CONTROL_1, 8'h82, q);
    repeat (2) @(posedge clk);
    chk("ext0 masked", 2'b00, {hi, lo});
    bus(1, OFS_IRQ_CONTROL_1, 8'h80, q);
    bus(1, OFS_IRQ_CONTROL_1, 8'h90, q);
    pin <= 4'h0;
    repeat (8) @(posedge clk);
    bus(0, OFS_IRQ_CONTROL_1, 0, q);
    chk("falling ignored", 32'h90, q);
    bus(1, OFS_IRQ_CONTROL_2, 8'hFB, q);
    bus(1, OFS_IRQ_CONTROL_1, 8'hE0, q);
    tcnt <= 16'h00FF;
    @(posedge clk);
    tcnt <= 16'h0000;
    await_req();
    chk("timer low", 2'b01, {hi, lo});
    sleep <= 1;
    repeat (3) @(posedge clk);
    chk("wake vector", 2'b11, {wake, wvec});
    bus(1, OFS_IRQ_CONTROL_1, 8'h64, q);
    repeat (2) @(posedge clk);
    chk("wake resume", 2'b10, {wake, wvec});
    bus(1, OFS_RESET_CONTROL, 8'h00, q);
    bus(1, OFS_PERIPH_ENABLE_1, 8'hFF, q);
    bus(1, OFS_PERIPH_FLAG_1, 8'hFF, q);
    bus(1, OFS_IRQ_CONTROL_1, 8'h80, q);
    repeat (2) @(posedge clk);
    chk("no peripheral_irq_enable", 2'b00, {hi, lo});
    bus(1, OFS_PERIPHERAL_PRIORITY_1, 8'h00, q);
    bus(1, OFS_IRQ_CONTROL_1, 8'hC0, q);
    repeat (2) @(posedge clk);
    chk("single level", 2'b10, {hi, lo});
    wrap_up();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule : irq_prio_tb
`default_nettype wire
